// ---- design/rtc_pkg.sv ----
// Constants, register map and types of the real-time clock.
// Assumes a 50 MHz bus clock and a 32.768 kHz time base pin.
// Operation
// - Select 1 puts the seconds clock on the pin, select 0 the alarm pulse.
// - The pin is driven only while the output enable bit is set.
// - Time is hours, minutes and seconds at half-second resolution.
// - Hours run 00 to 23 with no AM/PM flag.
// - Date, month, year, weekday and leap years cover 2000 to 2099.
// - Every field is BCD, one decimal digit per nibble.
// - The time base is the oscillator pin or the external input.
// - Master clear leaves the time base and counters running.
// - The value pointer picks min/sec, weekday/hours, month/day or year.
// - A value window write steps its pointer down, stopping at 00.
// - At 00 the value window keeps showing minutes and seconds.
// - The alarm pointer picks min/sec, weekday/hours, month/day or none.
// - An alarm window write steps its pointer down, stopping at 00.
// - Any read of either window steps its pointer down, stopping at 00.
// - Value window writes are dropped unless the unlock bit is set.
package rtc_pkg;

    localparam logic [7:0]  OFF_CLOCK_CFG  = 8'h00;
    localparam logic [7:0]  OFF_VALUE_WIN  = 8'h04;
    localparam logic [7:0]  OFF_ALARM_CFG  = 8'h08;
    localparam logic [7:0]  OFF_ALARM_WIN  = 8'h0C;
    localparam logic [7:0]  OFF_UNLOCK_KEY = 8'h10;
    localparam logic [7:0]  OFF_PAD_CFG    = 8'h14;
    localparam logic [7:0]  OFF_TB_SEL     = 8'h18;

    localparam int          CFG_ENABLE_BIT = 15;
    localparam int          CFG_UNLOCK_BIT = 13;
    localparam int          CFG_OE_BIT     = 10;
    localparam int          PAD_SECSEL_BIT = 1;
    localparam int          PAD_TTL_BIT    = 0;

    localparam logic [1:0]  PTR_MINSEC     = 2'h0;
    localparam logic [1:0]  PTR_WDHR       = 2'h1;
    localparam logic [1:0]  PTR_MONDAY     = 2'h2;
    localparam logic [1:0]  PTR_YEAR       = 2'h3;

    localparam logic [7:0]  KEY_FIRST      = 8'h55;
    localparam logic [7:0]  KEY_SECOND     = 8'hAA;
    localparam int          CLK_PERIOD_PS  = 20000;
    localparam int          INSTR_CYCLE_PS = 62500;
    localparam logic [2:0]  KEY_OPEN_CYCLES =
        3'(INSTR_CYCLE_PS / CLK_PERIOD_PS);

    localparam int          TB_FREQ_HZ     = 32768;
    localparam int          HALF_SEC_EDGES = TB_FREQ_HZ / 2;

    localparam logic [7:0]  SEC_LAST       = 8'h59;
    localparam logic [7:0]  MIN_LAST       = 8'h59;
    localparam logic [7:0]  HR_LAST        = 8'h23;
    localparam logic [7:0]  WDAY_LAST      = 8'h06;
    localparam logic [7:0]  MONTH_LAST     = 8'h12;
    localparam logic [7:0]  YEAR_LAST      = 8'h99;
    localparam logic [7:0]  FIRST_ONE      = 8'h01;
    localparam logic [7:0]  BCD_ZERO       = 8'h00;
    localparam logic [7:0]  MONTH_FEB      = 8'h02;
    localparam logic [7:0]  DAYS_31        = 8'h31;
    localparam logic [7:0]  DAYS_30        = 8'h30;
    localparam logic [7:0]  DAYS_29        = 8'h29;
    localparam logic [7:0]  DAYS_28        = 8'h28;
    localparam logic [7:0]  WDAY_RESET     = 8'h06;

    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_OPEN} key_state_t;

endpackage : rtc_pkg

// ---- design/cal_if.sv ----
// Counter writes and values between bus side and calendar.
// Assumes both ends run on the bus clock.
`timescale 1ns/1ps
`default_nettype none
interface cal_if;
    logic        tick;     // Half-second advance
    logic        wr;
    logic [1:0]  wr_idx;
    logic        wr_hi;
    logic        wr_lo;
    logic [15:0] wr_data;
    logic        half;     // Second half of the second
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hr;
    logic [7:0]  wday;
    logic [7:0]  day;
    logic [7:0]  month;
    logic [7:0]  year;

    modport ctrl (output tick, wr, wr_idx, wr_hi, wr_lo, wr_data,
                  input half, sec, min, hr, wday, day, month, year);
    modport cal  (input tick, wr, wr_idx, wr_hi, wr_lo, wr_data,
                  output half, sec, min, hr, wday, day, month, year);
endinterface : cal_if
`default_nettype wire

// ---- design/rtc_calendar.sv ----
// BCD time and calendar counters advanced by half-second ticks.
// Assumes ticks and writes are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar (
    input  wire logic hclk,    // Bus clock
    input  wire logic hresetn, // Power-on reset, active low
    cal_if.cal        c        // Counter port
);
    typedef struct packed {
        logic       half;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] wday;
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
    } cal_state_t;

    cal_state_t r_r;
    cal_state_t r_nxt;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            return {4'(v[7:4] + 4'h1), 4'h0};
        else
            return {v[7:4], 4'(v[3:0] + 4'h1)};
    endfunction : bcd_inc

    function automatic logic [7:0] month_last(input logic [7:0] m,
                                              input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == rtc_pkg::MONTH_FEB)
            return leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            return rtc_pkg::DAYS_30;
        else
            return rtc_pkg::DAYS_31;
    endfunction : month_last

    always_comb
    begin
        r_nxt = r_r;
        if (c.wr)
        begin
            case (c.wr_idx)
                rtc_pkg::PTR_MINSEC:
                begin
                    if (c.wr_hi) r_nxt.min = c.wr_data[15:8];
                    if (c.wr_lo)
                    begin
                        r_nxt.sec  = c.wr_data[7:0];
                        r_nxt.half = 1'b0;
                    end
                end
                rtc_pkg::PTR_WDHR:
                begin
                    if (c.wr_hi) r_nxt.wday = c.wr_data[15:8];
                    if (c.wr_lo) r_nxt.hr = c.wr_data[7:0];
                end
                rtc_pkg::PTR_MONDAY:
                begin
                    if (c.wr_hi) r_nxt.month = c.wr_data[15:8];
                    if (c.wr_lo) r_nxt.day = c.wr_data[7:0];
                end
                default:
                begin
                    if (c.wr_lo) r_nxt.year = c.wr_data[7:0];
                end
            endcase
        end
        else if (c.tick)
        begin
            r_nxt.half = ~r_r.half;
            if (r_r.half)
            begin
                r_nxt.sec = bcd_inc(r_r.sec);
                if (r_r.sec == rtc_pkg::SEC_LAST)
                begin
                    r_nxt.sec = rtc_pkg::BCD_ZERO;
                    r_nxt.min = bcd_inc(r_r.min);
                    if (r_r.min == rtc_pkg::MIN_LAST)
                    begin
                        r_nxt.min = rtc_pkg::BCD_ZERO;
                        r_nxt.hr  = bcd_inc(r_r.hr);
                        if (r_r.hr == rtc_pkg::HR_LAST)
                        begin
                            r_nxt.hr   = rtc_pkg::BCD_ZERO;
                            r_nxt.wday = (r_r.wday == rtc_pkg::WDAY_LAST)
                                ? rtc_pkg::BCD_ZERO : bcd_inc(r_r.wday);
                            r_nxt.day  = bcd_inc(r_r.day);
                            if (r_r.day == month_last(r_r.month, r_r.year))
                            begin
                                r_nxt.day   = rtc_pkg::FIRST_ONE;
                                r_nxt.month = bcd_inc(r_r.month);
                                if (r_r.month == rtc_pkg::MONTH_LAST)
                                begin
                                    r_nxt.month = rtc_pkg::FIRST_ONE;
                                    r_nxt.year  =
                                        (r_r.year == rtc_pkg::YEAR_LAST)
                                        ? rtc_pkg::BCD_ZERO
                                        : bcd_inc(r_r.year);
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // Only power-on reset touches the time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_r       <= '0;
            r_r.wday  <= rtc_pkg::WDAY_RESET;
            r_r.day   <= rtc_pkg::FIRST_ONE;
            r_r.month <= rtc_pkg::FIRST_ONE;
        end
        else
            r_r <= r_nxt;
    end

    assign c.half  = r_r.half;
    assign c.sec   = r_r.sec;
    assign c.min   = r_r.min;
    assign c.hr    = r_r.hr;
    assign c.wday  = r_r.wday;
    assign c.day   = r_r.day;
    assign c.month = r_r.month;
    assign c.year  = r_r.year;
endmodule : rtc_calendar
`default_nettype wire

// ---- design/rtc_top.sv ----
// Real-time clock with pointer windows on an AHB-Lite slave.
// Assumes time base pins synchronous to hclk, slower than hclk/2.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rtc_top #(
    parameter int HALF_SEC_EDGES = rtc_pkg::HALF_SEC_EDGES
) (
    input  wire logic        hclk,                    // Bus clock
    input  wire logic        hresetn,                 // Power-on reset
    input  wire logic        hsel,                    // Slave select
    input  wire logic [31:0] haddr,                   // Byte address
    input  wire logic [1:0]  htrans,                  // Transfer type
    input  wire logic        hwrite,                  // Write flag
    input  wire logic [2:0]  hsize,                   // Transfer size
    input  wire logic [31:0] hwdata,                  // Write data
    input  wire logic        hready,                  // Bus ready
    output logic      [31:0] hrdata,                  // Read data
    output logic             hreadyout,               // Slave ready
    output logic             hresp,                   // Always OKAY
    input  wire logic        secondary_oscillator,    // Time base source 0
    input  wire logic        external_timebase_input, // Time base source 1
    input  wire logic        master_clear_pin_n,      // Master clear pin
    output logic             clock_out,               // Seconds or alarm
    output logic             clock_out_en             // Pin drive enable
);
    typedef struct packed {
        logic                    dp_write;
        logic [7:0]              dp_addr;
        logic [31:0]             rdata;
        logic                    enable;
        logic                    unlock;
        logic                    oe;
        logic [1:0]              vptr;
        logic [7:0]              cal;
        logic [1:0]              aptr;
        logic [7:0]              a_min;
        logic [7:0]              a_sec;
        logic [7:0]              a_wd;
        logic [7:0]              a_hr;
        logic [7:0]              a_mon;
        logic [7:0]              a_day;
        logic                    secsel;
        logic                    ttl;
        logic                    tb_sel;
        rtc_pkg::key_state_t     key;
        logic [2:0]              key_cnt;
        logic                    tb_cur;
        logic                    tb_prev;
        logic [15:0]             tb_cnt;
        logic                    out;
        logic                    out_en;
        logic                    ready;
    } top_state_t;

    localparam logic [15:0] HALF_LAST = 16'(HALF_SEC_EDGES - 1);

    top_state_t r_r;
    top_state_t r_nxt;
    cal_if      c ();

    rtc_calendar u_calendar (
        .hclk    (hclk),
        .hresetn (hresetn),
        .c       (c)
    );

    logic        addr_ok;
    logic        wr_go;
    logic [7:0]  wb;
    logic        alarm_hit;

    always_comb
    begin
        r_nxt     = r_r;
        addr_ok   = hsel && htrans[1] && hready
                    && hsize == 3'h2 && haddr[31:8] == 24'h0;
        wr_go     = r_r.dp_write;
        wb        = hwdata[7:0];
        c.tick    = 1'b0;
        c.wr      = 1'b0;
        c.wr_idx  = r_r.vptr;
        c.wr_hi   = 1'b1;
        c.wr_lo   = 1'b1;
        c.wr_data = hwdata[15:0];
        alarm_hit = !c.half && c.sec == r_r.a_sec && c.min == r_r.a_min
                    && c.hr == r_r.a_hr;

        // Time base edges
        r_nxt.tb_cur  = r_r.tb_sel ? external_timebase_input
                                   : secondary_oscillator;
        r_nxt.tb_prev = r_r.tb_cur;
        if (r_r.enable && r_r.tb_cur && !r_r.tb_prev)
        begin
            if (r_r.tb_cnt == HALF_LAST)
            begin
                r_nxt.tb_cnt = '0;
                c.tick       = 1'b1;
            end
            else
                r_nxt.tb_cnt = 16'(r_r.tb_cnt + 16'h0001);
        end

        // Key window countdown
        if (r_r.key == rtc_pkg::KEY_OPEN)
        begin
            if (r_r.key_cnt <= 3'h1)
                r_nxt.key = rtc_pkg::KEY_IDLE;
            else
                r_nxt.key_cnt = 3'(r_r.key_cnt - 3'h1);
        end

        // Write data phase
        r_nxt.dp_write = 1'b0;
        if (wr_go)
        begin
            if (r_r.key == rtc_pkg::KEY_GOT_FIRST)
                r_nxt.key = rtc_pkg::KEY_IDLE;
            if (r_r.dp_addr == rtc_pkg::OFF_CLOCK_CFG)
            begin
                r_nxt.unlock = hwdata[rtc_pkg::CFG_UNLOCK_BIT]
                    && (r_r.unlock || r_r.key == rtc_pkg::KEY_OPEN);
                r_nxt.key = rtc_pkg::KEY_IDLE;
                if (r_r.unlock)
                    r_nxt.enable = hwdata[rtc_pkg::CFG_ENABLE_BIT];
                r_nxt.oe   = hwdata[rtc_pkg::CFG_OE_BIT];
                r_nxt.vptr = hwdata[9:8];
                r_nxt.cal  = wb;
            end
            else if (r_r.dp_addr == rtc_pkg::OFF_VALUE_WIN)
            begin
                c.wr = r_r.unlock;
                if (r_r.vptr != rtc_pkg::PTR_MINSEC)
                    r_nxt.vptr = 2'(r_r.vptr - 2'h1);
            end
            else if (r_r.dp_addr == rtc_pkg::OFF_ALARM_CFG)
                r_nxt.aptr = hwdata[9:8];
            else if (r_r.dp_addr == rtc_pkg::OFF_ALARM_WIN)
            begin
                case (r_r.aptr)
                    rtc_pkg::PTR_MINSEC:
                    begin
                        r_nxt.a_min = hwdata[15:8];
                        r_nxt.a_sec = wb;
                    end
                    rtc_pkg::PTR_WDHR:
                    begin
                        r_nxt.a_wd = hwdata[15:8];
                        r_nxt.a_hr = wb;
                    end
                    rtc_pkg::PTR_MONDAY:
                    begin
                        r_nxt.a_mon = hwdata[15:8];
                        r_nxt.a_day = wb;
                    end
                    default:
                    begin
                    end
                endcase
                if (r_r.aptr != rtc_pkg::PTR_MINSEC)
                    r_nxt.aptr = 2'(r_r.aptr - 2'h1);
            end
            else if (r_r.dp_addr == rtc_pkg::OFF_UNLOCK_KEY)
            begin
                if (wb == rtc_pkg::KEY_FIRST)
                    r_nxt.key = rtc_pkg::KEY_GOT_FIRST;
                else if (wb == rtc_pkg::KEY_SECOND
                         && r_r.key == rtc_pkg::KEY_GOT_FIRST)
                begin
                    r_nxt.key     = rtc_pkg::KEY_OPEN;
                    r_nxt.key_cnt = rtc_pkg::KEY_OPEN_CYCLES;
                end
                else
                    r_nxt.key = rtc_pkg::KEY_IDLE;
            end
            else if (r_r.dp_addr == rtc_pkg::OFF_PAD_CFG)
            begin
                r_nxt.secsel = hwdata[rtc_pkg::PAD_SECSEL_BIT];
                r_nxt.ttl    = hwdata[rtc_pkg::PAD_TTL_BIT];
            end
            else if (r_r.dp_addr == rtc_pkg::OFF_TB_SEL)
                r_nxt.tb_sel = hwdata[0];
        end

        // Address phase capture and read
        if (addr_ok)
        begin
            r_nxt.dp_write = hwrite;
            r_nxt.dp_addr  = haddr[7:0];
            r_nxt.rdata    = '0;
            if (!hwrite)
            begin
                if (haddr[7:0] == rtc_pkg::OFF_CLOCK_CFG)
                    r_nxt.rdata[15:0] = {r_r.enable, 1'b0, r_r.unlock, 1'b0,
                                         c.half, r_r.oe, r_r.vptr, r_r.cal};
                else if (haddr[7:0] == rtc_pkg::OFF_VALUE_WIN)
                begin
                    case (r_r.vptr)
                        rtc_pkg::PTR_MINSEC:
                            r_nxt.rdata[15:0] = {c.min, c.sec};
                        rtc_pkg::PTR_WDHR: r_nxt.rdata[15:0] = {c.wday, c.hr};
                        rtc_pkg::PTR_MONDAY:
                            r_nxt.rdata[15:0] = {c.month, c.day};
                        default: r_nxt.rdata[15:0] = {8'h00, c.year};
                    endcase
                    if (r_r.vptr != rtc_pkg::PTR_MINSEC)
                        r_nxt.vptr = 2'(r_r.vptr - 2'h1);
                end
                else if (haddr[7:0] == rtc_pkg::OFF_ALARM_CFG)
                    r_nxt.rdata[9:8] = r_r.aptr;
                else if (haddr[7:0] == rtc_pkg::OFF_ALARM_WIN)
                begin
                    case (r_r.aptr)
                        rtc_pkg::PTR_MINSEC:
                            r_nxt.rdata[15:0] = {r_r.a_min, r_r.a_sec};
                        rtc_pkg::PTR_WDHR:
                            r_nxt.rdata[15:0] = {r_r.a_wd, r_r.a_hr};
                        rtc_pkg::PTR_MONDAY:
                            r_nxt.rdata[15:0] = {r_r.a_mon, r_r.a_day};
                        default:
                            r_nxt.rdata[15:0] = 16'h0000;
                    endcase
                    if (r_r.aptr != rtc_pkg::PTR_MINSEC)
                        r_nxt.aptr = 2'(r_r.aptr - 2'h1);
                end
                else if (haddr[7:0] == rtc_pkg::OFF_PAD_CFG)
                    r_nxt.rdata[1:0] = {r_r.secsel, r_r.ttl};
                else if (haddr[7:0] == rtc_pkg::OFF_TB_SEL)
                    r_nxt.rdata[0] = r_r.tb_sel;
            end
        end

        // Master clear only drops a pending key
        if (!master_clear_pin_n)
            r_nxt.key = rtc_pkg::KEY_IDLE;

        // Output pin
        r_nxt.out_en = r_r.oe;
        r_nxt.out    = r_r.oe && (r_r.secsel ? c.half : alarm_hit);
        r_nxt.ready  = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end

    assign hrdata       = r_r.rdata;
    assign hreadyout    = r_r.ready;
    assign hresp        = 1'b0;
    assign clock_out    = r_r.out;
    assign clock_out_en = r_r.out_en;
endmodule : rtc_top
`default_nettype wire

// ---- tb/rtc_top_properties.sv ----
// Bus and pin checks for the clock top.
// Assumes single zero-wait word transfers; bound into rtc_top.
`timescale 1ns/1ps
`default_nettype none
module rtc_top_checker #(
    parameter int HALF_SEC_EDGES = 16384
) (
    input  wire logic        hclk,        // Clock
    input  wire logic        hresetn,     // Reset
    input  wire logic        hsel,        // Select
    input  wire logic [31:0] haddr,       // Address
    input  wire logic [1:0]  htrans,      // Type
    input  wire logic        hwrite,      // Write
    input  wire logic [2:0]  hsize,       // Size
    input  wire logic [31:0] hwdata,      // Wdata
    input  wire logic        hready,      // Ready
    input  wire logic [31:0] hrdata,      // Rdata
    input  wire logic        clock_out,   // Pin
    input  wire logic        clock_out_en // Pin enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       rd_r;
    logic       wr_r;
    logic [7:0] adr_r;
    logic [1:0] vptr_r;
    logic [1:0] rptr_r;
    logic       oe_r;
    logic       take;
    assign take = hsel && htrans[1] && hready && hsize == 3'h2 &&
                  haddr[31:8] == 24'h0;
    // Shadow of the value pointer and output enable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {rd_r, wr_r, adr_r, vptr_r, rptr_r, oe_r} <= 15'h0000;
        end
        else
        begin
            rd_r  <= take && !hwrite;
            wr_r  <= take && hwrite;
            adr_r <= haddr[7:0];
            if (take && !hwrite)
                rptr_r <= vptr_r;
            if (wr_r && adr_r == 8'h00)
                {oe_r, vptr_r} <= hwdata[10:8];
            else if (vptr_r != 2'h0 && ((wr_r && adr_r == 8'h04) ||
                     (take && !hwrite && haddr[7:0] == 8'h04)))
                vptr_r <= vptr_r - 2'h1;
        end
    end
    sequence s_win_read;
        rd_r && adr_r == 8'h04;
    endsequence
    property p_oe_gate;
        !clock_out_en |-> !clock_out;
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("pin active while disabled");
    property p_oe_follow;
        $stable(oe_r) [*2] |-> clock_out_en == oe_r;
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("pin enable differs from enable bit");
    property p_upper;
        rd_r |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper read half not zero");
    property p_bcd;
        s_win_read |-> hrdata[3:0] <= 4'h9 && hrdata[7:4] <= 4'h9 &&
            hrdata[11:8] <= 4'h9 && hrdata[15:12] <= 4'h9;
    endproperty
    a_bcd: assert property (p_bcd)
        else $error("window digit above nine");
    property p_year_only;
        s_win_read ##0 rptr_r == 2'h3 |-> hrdata[15:8] == 8'h00;
    endproperty
    a_year_only: assert property (p_year_only)
        else $error("year slot high byte not zero");
    property p_hours;
        s_win_read ##0 rptr_r == 2'h1 |-> hrdata[7:0] <= 8'h23;
    endproperty
    a_hours: assert property (p_hours)
        else $error("hours above 23");
    property p_month;
        s_win_read ##0 rptr_r == 2'h2 |-> hrdata[15:8] inside {[8'h01:8'h12]};
    endproperty
    a_month: assert property (p_month)
        else $error("month out of range");
    property p_ptr_step;
        rd_r && adr_r == 8'h00 |-> hrdata[9:8] == rptr_r;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("value pointer stepped wrongly");
    c_hours: cover property (s_win_read ##0 rptr_r == 2'h1);
    c_pin: cover property (clock_out_en && clock_out);
    c_oe: cover property ($rose(clock_out_en));
endmodule : rtc_top_checker
bind rtc_top rtc_top_checker #(.HALF_SEC_EDGES(HALF_SEC_EDGES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .clock_out(clock_out),
    .clock_out_en(clock_out_en));
`default_nettype wire

// ---- tb/rtc_calendar_register_windows_tb_top.sv ----
// Self-checking bench for the clock windows and output pin.
// Assumes rtc_top with a short tick count.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_register_windows_tb_top;
    typedef struct packed {
        logic [7:0]  a;
        logic        w;
        logic [15:0] d;
    } row_t;
    localparam row_t ROWS [30] = '{
        '{8'h00, 1'b0, 16'h0000}, '{8'h04, 1'b0, 16'h0000},
        '{8'h10, 1'b1, 16'h0055}, '{8'h10, 1'b1, 16'h00AA},
        '{8'h00, 1'b1, 16'h2300}, '{8'h00, 1'b0, 16'h2300},
        '{8'h04, 1'b1, 16'h0024}, '{8'h04, 1'b1, 16'h0228},
        '{8'h04, 1'b1, 16'h0323}, '{8'h04, 1'b1, 16'h5959},
        '{8'h00, 1'b0, 16'h2000}, '{8'h00, 1'b1, 16'hA300},
        '{8'h04, 1'b0, 16'h0024}, '{8'h04, 1'b0, 16'h0228},
        '{8'h04, 1'b0, 16'h0323}, '{8'h04, 1'b0, 16'h5959},
        '{8'h04, 1'b0, 16'h5959}, '{8'h08, 1'b1, 16'h0200},
        '{8'h0C, 1'b1, 16'h1225}, '{8'h0C, 1'b1, 16'h0000},
        '{8'h0C, 1'b1, 16'h0000}, '{8'h08, 1'b0, 16'h0000},
        '{8'h08, 1'b1, 16'h0300}, '{8'h0C, 1'b0, 16'h0000},
        '{8'h0C, 1'b0, 16'h1225}, '{8'h08, 1'b0, 16'h0100},
        '{8'h14, 1'b1, 16'h0002}, '{8'h14, 1'b0, 16'h0002},
        '{8'h20, 1'b0, 16'h0000}, '{8'h18, 1'b1, 16'h0000}};
    localparam logic [15:0] NEXT [4] = '{16'h0024, 16'h0229, 16'h0400,
                                         16'h0000};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        osc, ext, clr_n, clock_out, clock_out_en;
    int          n_errors, comparisons;
    rtc_top #(.HALF_SEC_EDGES(4)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .secondary_oscillator(osc),
        .external_timebase_input(ext), .master_clear_pin_n(clr_n),
        .clock_out(clock_out), .clock_out_en(clock_out_en));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [15:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        ahb(a, 1'b0, 16'h0000);
        check($sformatf("read %h", a), rd, {16'h0, e});
    endtask : rdchk
    task automatic pins(input logic [1:0] e);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check("pins", {30'h0, clock_out_en, clock_out}, {30'h0, e});
        @(posedge hclk);
    endtask : pins
    // Time base pulses, three cycles high and low
    task automatic pulses(input logic sel, input int n);
        repeat (n)
        begin
            {ext, osc} <= sel ? 2'b10 : 2'b01;
            repeat (3) @(posedge hclk);
            {ext, osc} <= 2'b00;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask : pulses
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial
    begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        final_report;
    end
    initial
    begin
        hresetn = 1'b0;
        clr_n   = 1'b1;
        {hsel, hwrite, osc, ext, htrans, hsize} = 9'h000;
        {haddr, hwdata} = 64'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ROWS[i])
        begin
            ahb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
            if (!ROWS[i].w)
                check("row", rd, {16'h0, ROWS[i].d});
        end
        $display("register table done");
        clr_n <= 1'b0;
        pulses(1'b0, 4);
        rdchk(8'h00, 16'hA800);
        pulses(1'b0, 4);
        clr_n <= 1'b1;
        ahb(8'h00, 1'b1, 16'hA300);
        foreach (NEXT[i])
            rdchk(8'h04, NEXT[i]);
        $display("rollover test done");
        ahb(8'h00, 1'b1, 16'hA400);
        pins(2'b10);
        ahb(8'h14, 1'b1, 16'h0000);
        pins(2'b11);
        ahb(8'h00, 1'b1, 16'hA000);
        pins(2'b00);
        $display("output pin test done");
        pulses(1'b1, 4);
        rdchk(8'h00, 16'hA000);
        ahb(8'h18, 1'b1, 16'h0001);
        pulses(1'b1, 4);
        rdchk(8'h00, 16'hA800);
        ahb(8'h18, 1'b1, 16'h0000);
        $display("time base test done");
        ahb(8'h00, 1'b1, 16'h8300);
        ahb(8'h04, 1'b1, 16'h0099);
        ahb(8'h00, 1'b1, 16'h8300);
        rdchk(8'h04, 16'h0024);
        ahb(8'h10, 1'b1, 16'h0055);
        ahb(8'h10, 1'b1, 16'h00AA);
        ahb(8'h14, 1'b1, 16'h0000);
        ahb(8'h00, 1'b1, 16'hA000);
        rdchk(8'h00, 16'h8800);
        $display("lock test done");
        final_report;
    end
endmodule : rtc_calendar_register_windows_tb_top
`default_nettype wire
